// File: hw/twe_pkg.sv
package twe_pkg;
    // Core clock rate and the timing figures it turns into cycle counts.
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned PROG_TIME_US = 1000;
    localparam int unsigned PROG_CYC_DEF = PROG_TIME_US * CLK_MHZ;
    localparam int unsigned RST_OUT_NS = 1000;
    localparam int unsigned RST_OUT_CYC = (RST_OUT_NS * CLK_MHZ) / 1000;
    localparam int unsigned RST_CNT_W = 8;

    // Array geometry.
    localparam int unsigned ROWS = 32;
    localparam int unsigned ROW_W = 5;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;

    // Register offsets and field positions.
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_ROW = 12'h008;
    localparam int unsigned CTRL_AUTO_BIT = 0;
    localparam int unsigned STAT_IDLE_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 1;
    localparam int unsigned STAT_FIELD_BIT = 2;
    localparam int unsigned STAT_AUTO_BIT = 3;
    localparam int unsigned STAT_STATE_LSB = 8;
    localparam logic AUTO_EN_RST = 1'b1;

    // Control byte codes.
    localparam logic [1:0] MODE_LO_INC = 2'h1;
    localparam logic [1:0] MODE_HI_DEC = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam logic [7:0] FILL0_CB = 8'h00;
    localparam logic [7:0] FILL1_CB = 8'hf8;
    localparam logic [7:0] SPEC_MASK = 8'hc7;
    localparam logic [7:0] SPEC_VAL = 8'hc7;
    localparam int unsigned PM_ON_BIT = 3;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CTRL = 7'h02,
        ST_ACK = 7'h04,
        ST_WDATA = 7'h08,
        ST_RDATA = 7'h10,
        ST_RACK = 7'h20,
        ST_SKIP = 7'h40
    } twe_state_e;
endpackage

// File: hw/twe_mem_if.sv
`timescale 1ns/10ps
interface twe_mem_if;
    import twe_pkg::*;
    logic [ROW_W-1:0] rd_row;
    logic [WORD_W-1:0] rd_data;
    logic op_en;
    logic op_all;
    logic [ROW_W-1:0] op_row;
    logic [WORD_W-1:0] op_data;
    modport ctl (output rd_row, output op_en, output op_all, output op_row, output op_data, input rd_data);
    modport arr (input rd_row, input op_en, input op_all, input op_row, input op_data, output rd_data);
endinterface

// File: hw/twe_array.sv
`timescale 1ns/10ps
module twe_array #(
    parameter int unsigned NROWS = twe_pkg::ROWS
) (
    input wire logic pclk,
    twe_mem_if.arr m
);
    import twe_pkg::*;

    logic [WORD_W-1:0] cell_r [NROWS];

    // The row index is five bits wide, so only a full power of two is served.
    if (NROWS != (1 << ROW_W)) begin : g_bad_rows
        $error("twe_array: NROWS must be 32");
    end

    // Cells are nonvolatile, so no reset touches them. One row or all rows take the word.
    for (genvar r = 0; r < NROWS; r++) begin : g_row
        always_ff @(posedge pclk) begin
            if (m.op_en && (m.op_all || (m.op_row == ROW_W'(r)))) begin
                cell_r[r] <= m.op_data;
            end
        end
    end

    // Whole-row read into the buffer.
    assign m.rd_data = cell_r[m.rd_row];
endmodule

// File: hw/twe_top.sv
`timescale 1ns/10ps
// What this block does
// - Data changes only while clock low; bits are valid while clock high.
// - Data edges while clock high are start or stop, never data.
// - Stop is a falling data edge while clock is high.
// - Transfers open with start, close with stop; stop returns to standby.
// - Receiver pulls data low during the ninth clock to acknowledge.
// - Without master acknowledge the device stops sending and listens.
// - Control byte: five row bits, two order bits, direction bit last.
// - Direction bit zero writes, one reads.
// - In standby the data line is released.
// - Array holds 32 rows of 16 bits, reached only serially.
// - Row address picks a row copied whole into the buffer.
// - Order bits choose high-then-low or low-then-high byte access.
// - Sequential reads step rows up or down without resending address.
// - Two control bytes fill the whole array with zeros or ones.
// - Write is control byte, one or two acknowledged data bytes, stop.
// - Write control loads the row; data bytes overwrite buffer in order.
// - While programming, inputs are ignored and acknowledges withheld.
// - Disabled auto switching stays off until reset, enable command or a control register write.
// - 11xx0111 disables and 11xx1111 enables automatic supply switching.
// - Mode 01 low first with increment; mode 10 high first with decrement.
// - Serial logic resets on power-on, field-to-battery switch, reset pin.
module twe_top #(
    parameter int unsigned PROG_CYC = twe_pkg::PROG_CYC_DEF,
    parameter bit STOP_ON_FALL = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic field_in,
    input wire logic reset_line_active_low_in,
    output logic reset_line_active_low_out,
    output logic reset_line_active_low_oe,
    output logic supply_on_field
);
    import twe_pkg::*;

    localparam int unsigned PW = $clog2(PROG_CYC + 1);
    localparam logic [PW-1:0] PROG_HALF = PW'(PROG_CYC / 2);
    localparam logic [PW-1:0] PROG_LAST = PW'(PROG_CYC - 1);
    localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_OUT_CYC);

    // The erase and write phases each need at least two cycles.
    if (PROG_CYC < 4) begin : g_bad_prog
        $error("twe_top: PROG_CYC must be at least 4");
    end

    // Which buffer byte is the high one for the given order and position.
    function automatic logic pick_hi(input logic [1:0] mode, input logic idx);
        pick_hi = (mode == MODE_HI_DEC) ^ idx;
    endfunction

    twe_mem_if mem ();

    twe_array #(.NROWS(ROWS)) u_array (
        .pclk(pclk),
        .m(mem.arr)
    );

    twe_state_e st_r;
    twe_state_e next_r;
    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;
    logic fld_m_r, fld_s_r;
    logic rl_m_r, rl_s_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic [ROW_W-1:0] row_r;
    logic [1:0] mode_r;
    logic idx_r;
    logic [1:0] wr_cnt_r;
    logic [WORD_W-1:0] buf_r;
    logic pend_r;
    logic fill_r;
    logic fill_one_r;
    logic ack_ok_r;
    logic busy_r;
    logic [PW-1:0] prog_cnt_r;
    logic auto_en_r;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic rst_oe_r;
    logic sda_oe_r;
    logic field_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic pready_r;

    logic scl_hi, scl_rise, scl_fall, sda_fall, sda_rise;
    logic start_ev, stop_ev, swback, ser_rst;
    logic ctrl_done, is_spec, is_fill, launch;
    logic [7:0] tx_nxt;
    logic apb_wr;

    // Every pin from the link passes two flip-flops before any logic sees it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
            fld_m_r <= 1'b0;
            fld_s_r <= 1'b0;
            rl_m_r <= 1'b1;
            rl_s_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            fld_m_r <= field_in;
            fld_s_r <= fld_m_r;
            rl_m_r <= reset_line_active_low_in;
            rl_s_r <= rl_m_r;
        end
    end

    // Edge detection on the synchronised link lines.
    assign scl_hi = scl_s_r & scl_d_r;
    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;
    assign sda_fall = sda_d_r & ~sda_s_r;
    assign sda_rise = ~sda_d_r & sda_s_r;

    // A data edge under a high clock is framing, never data. In standby only a falling edge counts,
    // as a start; once awake the stop edge ends the frame and the other edge restarts it.
    assign start_ev = scl_hi & ((st_r == ST_IDLE) ? sda_fall : (STOP_ON_FALL ? sda_rise : sda_fall));
    assign stop_ev = scl_hi & (st_r != ST_IDLE) & (STOP_ON_FALL ? sda_fall : sda_rise);

    // Supply switch-back and the reset pin both restart the serial logic.
    assign swback = field_r & ~fld_s_r;
    assign ser_rst = ~rl_s_r | swback;

    // Control byte decode, valid at the clock fall that ends its eighth bit.
    assign ctrl_done = (st_r == ST_CTRL) && scl_fall && (cnt_r == 4'h8);
    assign is_spec = (sh_r & SPEC_MASK) == SPEC_VAL;
    assign is_fill = (sh_r == FILL0_CB) || (sh_r == FILL1_CB);
    assign launch = stop_ev && pend_r && !busy_r && !ser_rst;

    // Next byte to send after an acknowledged one; a new word comes straight from the array.
    always_comb begin
        tx_nxt = 8'h00;
        if (idx_r) begin
            tx_nxt = pick_hi(mode_r, 1'b0) ? mem.rd_data[15:8] : mem.rd_data[7:0];
        end else begin
            tx_nxt = pick_hi(mode_r, 1'b1) ? buf_r[15:8] : buf_r[7:0];
        end
    end

    // Serial protocol engine.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;
            next_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            row_r <= '0;
            mode_r <= 2'h0;
            idx_r <= 1'b0;
            wr_cnt_r <= 2'h0;
            buf_r <= 16'h0000;
            pend_r <= 1'b0;
            fill_r <= 1'b0;
            fill_one_r <= 1'b0;
            ack_ok_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (ser_rst) begin
            st_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
            pend_r <= 1'b0;
        end else if (launch) begin
            st_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
            pend_r <= 1'b0;
        end else if (stop_ev) begin
            st_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
            pend_r <= 1'b0;
        end else if (start_ev) begin
            st_r <= ST_CTRL;
            cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            pend_r <= 1'b0;
            wr_cnt_r <= 2'h0;
        end else begin
            case (st_r)
                ST_CTRL, ST_WDATA: begin
                    if (scl_rise && cnt_r != 4'h8) begin
                        sh_r <= {sh_r[6:0], sda_s_r};
                        cnt_r <= cnt_r + 4'h1;
                    end
                    if (ctrl_done) begin
                        if (busy_r) begin
                            st_r <= ST_SKIP;
                        end else begin
                            row_r <= sh_r[7:3];
                            mode_r <= sh_r[2:1];
                            buf_r <= mem.rd_data;
                            sda_oe_r <= 1'b1;
                            st_r <= ST_ACK;
                            if (is_spec) begin
                                next_r <= ST_SKIP;
                            end else if (!sh_r[0]) begin
                                next_r <= (sh_r[2:1] == MODE_RSVD && !is_fill) ? ST_SKIP : ST_WDATA;
                                fill_r <= is_fill;
                                fill_one_r <= sh_r == FILL1_CB;
                                pend_r <= is_fill;
                            end else begin
                                next_r <= ST_RDATA;
                            end
                        end
                    end else if (st_r == ST_WDATA && scl_fall && cnt_r == 4'h8) begin
                        if (wr_cnt_r != 2'h2) begin
                            if (pick_hi(mode_r, wr_cnt_r[0])) begin
                                buf_r[15:8] <= sh_r;
                            end else begin
                                buf_r[7:0] <= sh_r;
                            end
                            wr_cnt_r <= wr_cnt_r + 2'h1;
                            pend_r <= 1'b1;
                        end
                        sda_oe_r <= 1'b1;
                        next_r <= ST_WDATA;
                        st_r <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= 4'h0;
                        st_r <= next_r;
                        idx_r <= 1'b0;
                        if (next_r == ST_RDATA) begin
                            tx_r <= pick_hi(mode_r, 1'b0) ? buf_r[15:8] : buf_r[7:0];
                            sda_oe_r <= pick_hi(mode_r, 1'b0) ? ~buf_r[15] : ~buf_r[7];
                        end else begin
                            sda_oe_r <= 1'b0;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_r == 4'h7) begin
                            sda_oe_r <= 1'b0;
                            st_r <= ST_RACK;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe_r <= ~tx_r[6];
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        ack_ok_r <= ~sda_s_r;
                        if (sda_s_r) begin
                            st_r <= ST_SKIP;
                        end else if (idx_r) begin
                            row_r <= (mode_r == MODE_HI_DEC) ? row_r - 5'h1 : row_r + 5'h1;
                        end
                    end else if (scl_fall && ack_ok_r) begin
                        if (idx_r) begin
                            buf_r <= mem.rd_data;
                        end
                        tx_r <= tx_nxt;
                        sda_oe_r <= ~tx_nxt[7];
                        idx_r <= ~idx_r;
                        cnt_r <= 4'h0;
                        st_r <= ST_RDATA;
                    end
                end
                default: begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // The array reads the row named by the arriving control byte, else the current row.
    assign mem.rd_row = (st_r == ST_CTRL) ? sh_r[7:3] : row_r;

    // Programming cycle timer; the acknowledge is held back until it ends.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            prog_cnt_r <= '0;
        end else if (launch) begin
            busy_r <= 1'b1;
            prog_cnt_r <= '0;
        end else if (busy_r) begin
            prog_cnt_r <= prog_cnt_r + PW'(1);
            if (prog_cnt_r == PROG_LAST) begin
                busy_r <= 1'b0;
            end
        end
    end

    // First cycle erases the cells, the halfway cycle writes the buffer or the fill value.
    assign mem.op_en = busy_r && (prog_cnt_r == '0 || prog_cnt_r == PROG_HALF);
    assign mem.op_all = fill_r;
    assign mem.op_row = row_r;
    assign mem.op_data = (prog_cnt_r == '0) ? 16'h0000 : (fill_r ? {WORD_W{fill_one_r}} : buf_r);

    // Automatic supply switching; a full reset, the enable command or a control register write turns it back on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_en_r <= AUTO_EN_RST;
        end else if (ctrl_done && !busy_r && is_spec) begin
            auto_en_r <= sh_r[PM_ON_BIT];
        end else if (apb_wr && paddr == OFF_CTRL) begin
            auto_en_r <= pwdata[CTRL_AUTO_BIT];
        end
    end

    // Field supply follows the field only while switching is enabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            field_r <= 1'b0;
        end else begin
            field_r <= auto_en_r & fld_s_r;
        end
    end

    // A switch back to battery pulls the reset line low for a while to reset the host too.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_r <= '0;
            rst_oe_r <= 1'b0;
        end else if (swback) begin
            rst_cnt_r <= RST_LOAD;
            rst_oe_r <= 1'b1;
        end else if (rst_cnt_r != '0) begin
            rst_cnt_r <= rst_cnt_r - RST_CNT_W'(1);
            rst_oe_r <= rst_cnt_r != RST_CNT_W'(1);
        end
    end

    // APB slave with zero wait states; read data is staged in the setup cycle.
    assign apb_wr = psel && penable && pwrite && pready_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            if (psel && !penable) begin
                prdata_r <= 32'h0000_0000;
                pslverr_r <= 1'b0;
                if (paddr == OFF_CTRL) begin
                    prdata_r[CTRL_AUTO_BIT] <= auto_en_r;
                end else if (paddr == OFF_STATUS) begin
                    prdata_r[STAT_IDLE_BIT] <= st_r == ST_IDLE;
                    prdata_r[STAT_BUSY_BIT] <= busy_r;
                    prdata_r[STAT_FIELD_BIT] <= field_r;
                    prdata_r[STAT_AUTO_BIT] <= auto_en_r;
                    prdata_r[STAT_STATE_LSB +: 7] <= st_r;
                end else if (paddr == OFF_ROW) begin
                    prdata_r[15:0] <= buf_r;
                    prdata_r[20:16] <= row_r;
                    prdata_r[25:24] <= mode_r;
                end else begin
                    pslverr_r <= 1'b1;
                end
            end
        end
    end

    // Pin and bus outputs, straight from flip-flops or tied low; the data line is open drain.
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;
    assign reset_line_active_low_out = 1'b0;
    assign reset_line_active_low_oe = rst_oe_r;
    assign supply_on_field = field_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign pready = pready_r;
endmodule

// File: verification/twe_top_checker.sv
`timescale 1ns/10ps
module twe_top_checker
    import twe_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic field_in,
    input wire logic reset_line_active_low_in,
    input wire logic reset_line_active_low_out,
    input wire logic reset_line_active_low_oe,
    input wire logic supply_on_field
);
    // Counts how long the reset pin has been pulled; a pulse cut short would go unseen otherwise.
    logic [7:0] rst_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_r <= 8'h00;
        end else begin
            rst_cnt_r <= reset_line_active_low_oe ? rst_cnt_r + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A falling data edge with the clock high frames a transfer.
    sequence s_frame_edge;
        scl_in && $fell(sda_in);
    endsequence
    sequence s_field_lost;
        $fell(supply_on_field) && !field_in;
    endsequence
    a_open_drain_low: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    a_oe_scl_low: assert property ($changed(sda_oe) && reset_line_active_low_in |-> !scl_in)
        else $error("data changed with clock high");
    a_oe_reset_pin: assert property (!reset_line_active_low_in [*6] |-> !sda_oe)
        else $error("data held during reset pin");
    a_stop_releases: assert property (s_frame_edge |-> !sda_oe [*8])
        else $error("data not released at frame edge");
    a_supply_field: assert property (!field_in [*5] |-> !supply_on_field)
        else $error("field supply without field");
    a_swback_start: assert property (s_field_lost |-> ##[0:3] reset_line_active_low_oe)
        else $error("no reset pulse on switchback");
    a_swback_cause: assert property ($rose(reset_line_active_low_oe) |-> !field_in && !supply_on_field)
        else $error("reset pulse without switchback");
    a_swback_len: assert property ($fell(reset_line_active_low_oe) |-> rst_cnt_r == RST_OUT_CYC)
        else $error("reset pulse length wrong");
endmodule
bind twe_top twe_top_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_in, .sda_in, .sda_out, .sda_oe, .field_in, .reset_line_active_low_in,
    .reset_line_active_low_out, .reset_line_active_low_oe, .supply_on_field);

// File: verification/twe_host.sv
`timescale 1ns/10ps
module twe_host (
    output logic scl,
    output logic pull,
    input wire logic sda
);
    // The link idles with the clock high and data left to its pull-up.
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Data moves only in the low half; the wire is read in the high half.
    task automatic bit_io(input logic b, output logic s);
        #16 pull = ~b;
        #16 scl = 1'b1;
        #16 s = sda;
        #16 scl = 1'b0;
    endtask
    // A falling data edge with the clock high wakes the device.
    task automatic start();
        pull = 1'b1;
        #16 scl = 1'b0;
    endtask
    // Stop is a falling edge too; the release after it is ignored in standby.
    task automatic stop();
        #16 pull = 1'b0;
        #16 scl = 1'b1;
        #16 pull = 1'b1;
        #32 pull = 1'b0;
        #32;
    endtask
    // Parks the clock high after an aborted frame without any data edge.
    task automatic idle();
        #16 pull = 1'b0;
        #16 scl = 1'b1;
        #32;
    endtask
    // Sends a byte MSB first; the ninth clock reads the acknowledge.
    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // Receives a byte MSB first, then acknowledges it or not.
    task automatic rd(input logic mack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(~mack, s);
    endtask
endmodule

// File: verification/twe_top_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module twe_top_tb;
    import twe_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scl_in, pull, field_in, rst_drv;
    logic sda_out, sda_oe, rst_out, rst_oe, sof, e, a;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int checked = 0;
    int failures = 0;
    wire sda_in = ~(pull | (sda_oe & ~sda_out));
    wire rst_pin = rst_drv & ~(rst_oe & ~rst_out);
    twe_top #(.PROG_CYC(400)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .scl_in, .sda_in, .sda_out, .sda_oe, .field_in, .reset_line_active_low_in(rst_pin),
        .reset_line_active_low_out(rst_out), .reset_line_active_low_oe(rst_oe), .supply_on_field(sof));
    twe_host i_host (.scl(scl_in), .pull, .sda(sda_in));
    // Core clock, 5 ns period.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // One APB transfer; the request is held until pready is seen at an access edge.
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) failures++;
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Waits out programming under a bounded count, then expects standby.
    task automatic wait_idle();
        int n = 0;
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("busy", 1'b1, q[STAT_BUSY_BIT])
        do apb(1'b0, OFF_STATUS, 32'h0); while (q[STAT_BUSY_BIT] !== 1'b0 && ++n < 200);
        `CHK("status", 32'h0000_0109, q)
    endtask
    // Write frame, then one poll that must go unanswered while busy.
    task automatic wr_seq(input logic [7:0] cb, input logic [23:0] d, input int n);
        i_host.start();
        i_host.wr(cb, a);
        `CHK("ctrl_ack", 1'b1, a)
        for (int i = 0; i < n; i++) begin
            i_host.wr(d[23-8*i -: 8], a);
            `CHK("data_ack", 1'b1, a)
        end
        i_host.stop();
        i_host.start();
        i_host.wr(8'h01, a);
        `CHK("poll_ack", 1'b0, a)
        i_host.stop();
        wait_idle();
    endtask
    // Four-byte sequential read, the last byte left unacknowledged.
    task automatic rd_seq(input logic [7:0] cb, input logic [31:0] x);
        logic [7:0] b;
        i_host.start();
        i_host.wr(cb, a);
        `CHK("rctrl_ack", 1'b1, a)
        for (int i = 0; i < 4; i++) begin
            i_host.rd(i < 3, b);
            `CHK("rd_byte", x[31-8*i -: 8], b)
        end
        i_host.stop();
    endtask
    // Sends a one-byte special command frame.
    task automatic cmd(input logic [7:0] cb);
        i_host.start();
        i_host.wr(cb, a);
        `CHK("cmd_ack", 1'b1, a)
        i_host.stop();
        repeat (8) @(posedge pclk);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, field_in, rst_drv} = {4'h0, 12'h000, 32'h0, 2'b01};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK("ctrl", 32'h0000_0001, q)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {e, q})
        wr_seq(FILL0_CB, 24'h00_0000, 0);
        wr_seq({5'd5, MODE_LO_INC, 1'b0}, 24'ha5_0000, 1);
        wr_seq({5'd6, MODE_HI_DEC, 1'b0}, 24'h12_3456, 3);
        rd_seq({5'd5, MODE_LO_INC, 1'b1}, 32'ha500_3412);
        rd_seq({5'd6, MODE_HI_DEC, 1'b1}, 32'h1234_00a5);
        // A reset pin pulse in mid-write drops the pending write.
        i_host.start();
        i_host.wr({5'd7, MODE_LO_INC, 1'b0}, a);
        i_host.wr(8'h77, a);
        @(posedge pclk) rst_drv <= 1'b0;
        repeat (10) @(posedge pclk);
        `CHK("oe_rst", 1'b0, sda_oe)
        rst_drv <= 1'b1;
        i_host.idle();
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("status_rst", 32'h0000_0109, q)
        rd_seq({5'd7, MODE_LO_INC, 1'b1}, 32'h0000_0000);
        wr_seq(FILL1_CB, 24'h00_0000, 0);
        wr_seq({5'd0, MODE_LO_INC, 1'b0}, 24'h3c_0000, 1);
        rd_seq({5'd31, MODE_LO_INC, 1'b1}, 32'hffff_3cff);
        // Supply switching by register, by command, and the switchback pulse.
        @(posedge pclk) field_in <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("sof_on", 1'b1, sof)
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK("sof_reg", 33'h0_0000_0000, {sof, q})
        apb(1'b1, OFF_CTRL, 32'h1);
        cmd(8'hc7);
        `CHK("sof_cmd", 2'b00, {sof, rst_oe})
        @(posedge pclk) field_in <= 1'b0;
        repeat (8) @(posedge pclk) field_in <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("sof_stay", 1'b0, sof)
        cmd(8'hcf);
        `CHK("sof_en", 1'b1, sof)
        @(posedge pclk) field_in <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK("swback", 1'b1, rst_oe)
        repeat (250) @(posedge pclk);
        `CHK("swback_end", 1'b0, rst_oe)
        tally_and_finish();
    end
    // Watchdog well beyond the expected run.
    initial begin
        #150000;
        failures++;
        tally_and_finish();
    end
endmodule
